// ===== hw/sbl_params.svh
// timing counts and widths for the bank command legality block
`ifndef SBL_PARAMS_SVH
`define SBL_PARAMS_SVH
`define SBL_NBANK     4
`define SBL_CNT_W     8
`define SBL_T_CLK_PS  5000
// precharge, activate-to-access, refresh, mode load, write recovery
`define SBL_T_RP_NS   15
`define SBL_T_RCD_NS  15
`define SBL_T_RFC_NS  72
`define SBL_T_MRD_NS  10
`define SBL_T_WR_NS   15
// least times round up to whole clock cycles
`define SBL_CYC(ns) (((ns) * 1000 + `SBL_T_CLK_PS - 1) / `SBL_T_CLK_PS)
`define SBL_RP_CYC   8'(`SBL_CYC(`SBL_T_RP_NS))
`define SBL_RCD_CYC  8'(`SBL_CYC(`SBL_T_RCD_NS))
`define SBL_RFC_CYC  8'(`SBL_CYC(`SBL_T_RFC_NS))
`define SBL_MRD_CYC  8'(`SBL_CYC(`SBL_T_MRD_NS))
`define SBL_WR_CYC   8'(`SBL_CYC(`SBL_T_WR_NS))
// burst length 4 takes two clocks of data
`define SBL_BURST_CYC 8'h02
`endif

// ===== hw/sbl_pkg.sv
// types shared by the bank command legality block
package sbl_pkg;
  // decoded command on the bus
  typedef enum logic [3:0] {
    CMD_NOP  = 4'h0,
    CMD_ACT  = 4'h1,
    CMD_RD   = 4'h2,
    CMD_WR   = 4'h3,
    CMD_PRE  = 4'h4,
    CMD_PREA = 4'h5,
    CMD_BST  = 4'h6,
    CMD_REF  = 4'h7,
    CMD_LMR  = 4'h8
  } sbl_cmd_t;
  // per-bank state, one-hot
  typedef enum logic [7:0] {
    BK_IDLE   = 8'h01,
    BK_ACTING = 8'h02,
    BK_ACTIVE = 8'h04,
    BK_READ   = 8'h08,
    BK_WRITE  = 8'h10,
    BK_RDAP   = 8'h20,
    BK_WRAP   = 8'h40,
    BK_PRECH  = 8'h80
  } sbl_bank_st_t;
  // device-wide state, one-hot
  typedef enum logic [3:0] {
    GL_RUN  = 4'h1,
    GL_REF  = 4'h2,
    GL_MRD  = 4'h4,
    GL_PALL = 4'h8
  } sbl_glob_st_t;
  // command bus pins as sampled
  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [1:0] ba;
    logic       ap;
  } sbl_bus_t;
  // bank tracker state
  typedef struct packed {
    sbl_bank_st_t st;
    logic [7:0]   cnt;
  } sbl_bank_t;
endpackage : sbl_pkg

// ===== hw/sbl_bank.sv
// one bank's state and timing tracker
`timescale 1ns/10ps
`include "sbl_params.svh"
module sbl_bank
  import sbl_pkg::*;
(
  input  wire logic   clk_sys_i,
  input  wire logic   rst_n_i,
  input  wire logic   go_i,      // legal command accepted this edge
  input  wire logic   hit_i,     // command addresses this bank
  input  wire logic   bst_i,     // burst terminate for this bank
  input  wire logic   wr_blk_i,  // a read burst without auto precharge still runs
  input  sbl_cmd_t    cmd_i,
  input  wire logic   ap_i,
  output sbl_bank_st_t st_o,     // registered state
  output wire logic   ok_o,      // command legal to this bank
  output wire logic   idle_o,    // idle once timers step
  output wire logic   rd_o       // read burst without auto precharge running
);
  sbl_bank_t cur_r;
  sbl_bank_t eff;   // state after this edge's timer step
  sbl_bank_t nxt;
  logic      ok;

  // timer step first, so a window that ends this edge frees the bank
  always_comb begin
    eff = cur_r;
    if (cur_r.cnt != 8'h00) begin
      eff.cnt = cur_r.cnt - 8'h01;
    end else begin
      case (cur_r.st)
        BK_ACTING: eff.st = BK_ACTIVE;
        BK_PRECH:  eff.st = BK_IDLE;
        BK_READ:   eff.st = BK_ACTIVE;
        BK_WRITE:  eff.st = BK_ACTIVE;
        BK_RDAP, BK_WRAP: begin
          // access period over, precharge period follows
          eff.st  = BK_PRECH;
          eff.cnt = `SBL_RP_CYC - 8'h01;
        end
        default: eff.st = cur_r.st;
      endcase
    end
  end

  // same-bank legality on the stepped state
  always_comb begin
    case (eff.st)
      BK_IDLE:   ok = cmd_i inside {CMD_ACT, CMD_PRE, CMD_PREA};
      BK_ACTIVE,
      BK_READ,
      BK_WRITE:  ok = cmd_i inside {CMD_RD, CMD_PRE, CMD_PREA}
                   || (cmd_i == CMD_WR && !wr_blk_i);
      default:   ok = 1'b0;  // busy states take nothing
    endcase
  end

  // apply an accepted command over the stepped state
  always_comb begin
    nxt = eff;
    if (go_i && hit_i) begin
      case (cmd_i)
        CMD_ACT: begin
          nxt.st  = BK_ACTING;
          nxt.cnt = `SBL_RCD_CYC - 8'h01;
        end
        CMD_RD: begin
          // auto precharge bit picks the variant
          nxt.st  = ap_i ? BK_RDAP : BK_READ;
          nxt.cnt = `SBL_BURST_CYC - 8'h01;
        end
        CMD_WR: begin
          nxt.st  = ap_i ? BK_WRAP : BK_WRITE;
          // write recovery counted only with auto precharge
          nxt.cnt = ap_i ? `SBL_BURST_CYC + `SBL_WR_CYC - 8'h01
                         : `SBL_BURST_CYC - 8'h01;
        end
        CMD_PRE, CMD_PREA: begin
          // precharging an idle bank leaves it idle
          if (eff.st != BK_IDLE) begin
            nxt.st  = BK_PRECH;
            nxt.cnt = `SBL_RP_CYC - 8'h01;
          end
        end
        default: nxt = eff;
      endcase
    end else if (go_i && bst_i && eff.st == BK_READ) begin
      nxt.st  = BK_ACTIVE;
      nxt.cnt = 8'h00;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_r <= '{st: BK_IDLE, cnt: 8'h00};
    end else begin
      cur_r <= nxt;
    end
  end

  assign st_o   = cur_r.st;
  assign ok_o   = ok;
  assign idle_o = (eff.st == BK_IDLE);
  assign rd_o   = (eff.st == BK_READ);
endmodule : sbl_bank

// ===== hw/sbl_core.sv
// command legality and state tracking for a four-bank sdram
// Behaviour
// - check only with clock enable high twice, ready
// - idle only after precharge and tRP
// - row active after activate plus tRCD
// - read/write state until burst ends or cut
// - precharging lasts tRP, then idle
// - activating lasts tRCD, then row active
// - auto precharge access busy until tRP, idle
// - refresh lasts tRFC, then all idle
// - mode register load lasts tMRD
// - precharge-all lasts tRP, all idle
// - burst terminate cuts latest read without auto precharge
// - read/write both variants via auto precharge bit
// - idle bank n: other banks by own state
// - busy bank n: other banks by own state; here a read burst without auto precharge in bank n blocks writes to every bank
// - command encoding on select, ras, cas, we
// - auto precharge splits access, precharge period
// - write auto precharge waits write recovery
// - auto precharge bank lets others proceed
`timescale 1ns/10ps
`include "sbl_params.svh"
module sbl_core
  import sbl_pkg::*;
(
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic          cke_i,      // clock enable pin
  input  wire logic          ready_i,    // exit period or init done
  input  sbl_bus_t           bus_i,      // command pins
  output logic               cmd_ok_o,   // executable command taken
  output logic               cmd_err_o,  // illegal command seen
  output logic               all_idle_o, // every bank idle
  output sbl_glob_st_t       glob_st_o,  // device-wide state
  output sbl_bank_st_t [3:0] bank_st_o   // per-bank state
);
  // whole module state
  typedef struct packed {
    logic               cke_q;
    sbl_glob_st_t       gst;
    logic [7:0]         gcnt;
    logic [1:0]         last_rd;
    logic               last_vld;
    logic               ok;
    logic               err;
    logic               idle;
    sbl_glob_st_t       gst_o;
    sbl_bank_st_t [3:0] bst_o;
  } sbl_core_t;

  sbl_core_t          cur_r;
  sbl_core_t          cur_nxt;
  sbl_cmd_t           cmd;       // decoded command
  logic               chk;       // legality window open
  logic               go;        // legal command accepted
  logic               legal;
  logic               exec;      // command does something
  sbl_glob_st_t       g_eff;     // global state after timer step
  logic [7:0]         g_cnt_eff;
  logic [3:0]         b_ok;
  logic [3:0]         b_idle;
  logic [3:0]         b_rd;
  logic [3:0]         b_hit;
  logic [3:0]         b_bst;
  sbl_bank_st_t [3:0] b_st;

  // pin decode; deselect and nop keep the previous operation
  always_comb begin
    if (bus_i.cs_n) begin
      cmd = CMD_NOP;
    end else begin
      case ({bus_i.ras_n, bus_i.cas_n, bus_i.we_n})
        3'h7:    cmd = CMD_NOP;
        3'h3:    cmd = CMD_ACT;
        3'h5:    cmd = CMD_RD;
        3'h4:    cmd = CMD_WR;
        3'h2:    cmd = bus_i.ap ? CMD_PREA : CMD_PRE;
        3'h6:    cmd = CMD_BST;
        3'h1:    cmd = CMD_REF;
        default: cmd = CMD_LMR;
      endcase
    end
  end

  // the table holds only with clock enable high on both edges
  assign chk  = cke_i && cur_r.cke_q && ready_i;
  assign exec = (cmd != CMD_NOP);

  // global timer step, same ordering as the banks
  always_comb begin
    g_eff     = cur_r.gst;
    g_cnt_eff = cur_r.gcnt;
    if (cur_r.gcnt != 8'h00) begin
      g_cnt_eff = cur_r.gcnt - 8'h01;
    end else begin
      g_eff = GL_RUN;
    end
  end

  // legality: per-bank for bank commands, global for the rest
  always_comb begin
    case (cmd)
      CMD_NOP:  legal = 1'b1;
      CMD_ACT,
      CMD_RD,
      CMD_WR,
      CMD_PRE:  legal = b_ok[bus_i.ba];
      CMD_PREA: legal = &b_ok;
      CMD_BST:  legal = 1'b1;
      CMD_REF,
      CMD_LMR:  legal = &b_idle;
      default:  legal = 1'b0;
    endcase
    // device-wide windows admit no executable command
    if (g_eff != GL_RUN && exec) begin
      legal = 1'b0;
    end
  end

  assign go = chk && legal && exec;

  // bank selection; precharge-all reaches every bank
  always_comb begin
    for (int i = 0; i < `SBL_NBANK; i++) begin
      b_hit[i] = (cmd == CMD_PREA)
              || (cmd inside {CMD_ACT, CMD_RD, CMD_WR, CMD_PRE}
                  && bus_i.ba == 2'(i));
      b_bst[i] = (cmd == CMD_BST) && cur_r.last_vld
              && cur_r.last_rd == 2'(i);
    end
  end

  // one tracker per bank
  for (genvar g = 0; g < `SBL_NBANK; g++) begin : g_bank
    sbl_bank u_bank (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .go_i      (go),
      .hit_i     (b_hit[g]),
      .bst_i     (b_bst[g]),
      .wr_blk_i  (|b_rd),
      .cmd_i     (cmd),
      .ap_i      (bus_i.ap),
      .st_o      (b_st[g]),
      .ok_o      (b_ok[g]),
      .idle_o    (b_idle[g]),
      .rd_o      (b_rd[g])
    );
  end

  // next state of the module
  always_comb begin
    cur_nxt       = cur_r;
    cur_nxt.cke_q = cke_i;
    cur_nxt.gst   = g_eff;
    cur_nxt.gcnt  = g_cnt_eff;
    if (go) begin
      case (cmd)
        CMD_REF: begin
          cur_nxt.gst  = GL_REF;
          cur_nxt.gcnt = `SBL_RFC_CYC - 8'h01;
        end
        CMD_LMR: begin
          cur_nxt.gst  = GL_MRD;
          cur_nxt.gcnt = `SBL_MRD_CYC - 8'h01;
        end
        CMD_PREA: begin
          cur_nxt.gst  = GL_PALL;
          cur_nxt.gcnt = `SBL_RP_CYC - 8'h01;
        end
        CMD_RD: begin
          // remember the latest read for burst terminate
          cur_nxt.last_rd  = bus_i.ba;
          cur_nxt.last_vld = !bus_i.ap;
        end
        CMD_BST: cur_nxt.last_vld = 1'b0;
        default: cur_nxt.last_vld = cur_r.last_vld;
      endcase
    end
    // outputs are registered copies, one edge late
    cur_nxt.ok    = go;
    cur_nxt.err   = chk && !legal;
    cur_nxt.idle  = &b_idle;
    cur_nxt.gst_o = cur_r.gst;
    cur_nxt.bst_o = b_st;
  end

  // single register for all module state
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_r <= '{cke_q: 1'b0, gst: GL_RUN, gcnt: 8'h00, last_rd: 2'h0,
                 last_vld: 1'b0, ok: 1'b0, err: 1'b0, idle: 1'b1,
                 gst_o: GL_RUN, bst_o: '{default: BK_IDLE}};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  assign cmd_ok_o   = cur_r.ok;
  assign cmd_err_o  = cur_r.err;
  assign all_idle_o = cur_r.idle;
  assign glob_st_o  = cur_r.gst_o;
  assign bank_st_o  = cur_r.bst_o;

  // checks on the tracker
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  no_check_err_a : assert property (
    !chk |=> !cmd_err_o)
    else $error("error flagged outside the legality window");

  // the window ends on the edge a new command may already be taken,
  // so the exit is judged on the timer-stepped state of that edge
  act_window_a : assert property (
    go && cmd == CMD_ACT && bus_i.ba == 2'h0
    |=> (b_st[0] == BK_ACTING) [*3] ##0 g_bank[0].u_bank.eff.st == BK_ACTIVE)
    else $error("activate window not three cycles");

  pre_window_a : assert property (
    go && cmd == CMD_PRE && bus_i.ba == 2'h0 && b_st[0] == BK_ACTIVE
    |=> (b_st[0] == BK_PRECH) [*3] ##0 g_bank[0].u_bank.eff.st == BK_IDLE)
    else $error("precharge window not three cycles");

  ref_window_a : assert property (
    go && cmd == CMD_REF
    |=> cur_r.gst == GL_REF ##14 cur_r.gst == GL_REF
        ##0 g_eff == GL_RUN)
    else $error("refresh window wrong length");

  busy_block_a : assert property (
    chk && cur_r.gst == GL_REF && cur_r.gcnt != 8'h00 && exec
    |=> cmd_err_o && !cmd_ok_o)
    else $error("command accepted during refresh");

  idle_need_a : assert property (
    chk && cmd inside {CMD_REF, CMD_LMR} && !(&b_idle) |=> cmd_err_o)
    else $error("refresh or mode load accepted with bank open");

  bst_cut_a : assert property (
    go && cmd == CMD_BST && cur_r.last_vld && cur_r.last_rd == 2'h0
    && b_st[0] == BK_READ && cur_r.gst == GL_RUN
    |=> b_st[0] == BK_ACTIVE)
    else $error("burst terminate did not cut the read");

  wrap_seq_a : assert property (
    go && cmd == CMD_WR && bus_i.ap && bus_i.ba == 2'h2
    |=> (b_st[2] == BK_WRAP) [*5] ##1 (b_st[2] == BK_PRECH) [*3]
        ##0 g_bank[2].u_bank.eff.st == BK_IDLE)
    else $error("write auto precharge sequence wrong");

  rdap_seq_a : assert property (
    go && cmd == CMD_RD && bus_i.ap && bus_i.ba == 2'h1
    |=> (b_st[1] == BK_RDAP) [*2] ##1 (b_st[1] == BK_PRECH) [*3]
        ##0 g_bank[1].u_bank.eff.st == BK_IDLE)
    else $error("read auto precharge sequence wrong");

  // row counts as open on the edge its activate window runs out
  other_bank_a : assert property (
    chk && cur_r.gst == GL_RUN && g_bank[1].u_bank.eff.st == BK_ACTIVE
    && !(|b_rd) && cmd == CMD_RD && bus_i.ba == 2'h1 |=> cmd_ok_o)
    else $error("read to open bank refused");

  act_cov_c  : cover property (go && cmd == CMD_ACT);
  ref_cov_c  : cover property (go && cmd == CMD_REF);
  bst_cov_c  : cover property (go && cmd == CMD_BST && cur_r.last_vld);
  err_cov_c  : cover property (cmd_err_o);
endmodule : sbl_core

// ===== testbench/sbl_ctl_model.sv
// memory controller model that drives the command pins
`timescale 1ns/10ps
module sbl_ctl_model
  import sbl_pkg::*;
(
  input  wire logic clk_sys_i, // memory clock
  output sbl_bus_t  bus_o      // command pins
);
  initial bus_o = 7'h40;
  // one command at the next edge; the bench chooses legal or not
  task automatic issue(input sbl_cmd_t c, input logic [1:0] ba, input logic ap);
    logic [2:0] rcw;
    case (c)
      CMD_ACT: rcw = 3'h3;
      CMD_RD:  rcw = 3'h5;
      CMD_WR:  rcw = 3'h4;
      CMD_PRE, CMD_PREA: rcw = 3'h2;
      CMD_BST: rcw = 3'h6;
      CMD_REF: rcw = 3'h1;
      CMD_LMR: rcw = 3'h0;
      default: rcw = 3'h7;
    endcase
    @(posedge clk_sys_i);
    bus_o <= {1'b0, rcw, ba, ap | (c == CMD_PREA)};
  endtask : issue
  // deselect; other lines flip so no stale command lingers
  task automatic idle();
    @(posedge clk_sys_i);
    bus_o <= {1'b1, ~bus_o[5:0]};
  endtask : idle
endmodule : sbl_ctl_model

// ===== testbench/test_sbl_bank_command_legality.sv
// self-checking bench for the bank command legality block
`timescale 1ns/10ps
module test_sbl_bank_command_legality
  import sbl_pkg::*;
;
  localparam int RCD = 3;  // activate window
  localparam int RP  = 3;  // precharge window
  localparam int RFC = 15; // refresh window
  localparam int MRD = 2;  // mode load window
  localparam int WAP = 5;  // write burst plus recovery
  localparam int BUR = 2;  // burst of four
  localparam logic [1:0] OK = 2'h2;
  localparam logic [1:0] ER = 2'h1;
  localparam logic [1:0] NO = 2'h0;
  logic               clk_sys_i;
  logic               rst_n_i;
  logic               cke_i;
  logic               ready_i;
  logic               cmd_ok_o;
  logic               cmd_err_o;
  logic               all_idle_o;
  sbl_bus_t           bus;
  sbl_glob_st_t       glob_st_o;
  sbl_bank_st_t [3:0] bank_st_o;
  logic [1:0]         exp_bus;  // expected answer of the command on the pins
  logic [1:0]         exp_p1;
  int                 fail_count;
  int                 n_tests;
  int                 st_cnt [4][8]; // cycles seen per bank state bit
  int                 gl_cnt [4];    // cycles seen per global state bit

  sbl_ctl_model i_ctl (.clk_sys_i(clk_sys_i), .bus_o(bus));
  sbl_core i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cke_i(cke_i),
    .ready_i(ready_i), .bus_i(bus), .cmd_ok_o(cmd_ok_o), .cmd_err_o(cmd_err_o),
    .all_idle_o(all_idle_o), .glob_st_o(glob_st_o), .bank_st_o(bank_st_o));

  // 200 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk_v(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask : chk_v

  task automatic chk_n(input string nm, input int e, input int g);
    n_tests++;
    if (g != e) begin
      fail_count++;
      $display("unexpected %s: expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_n

  // pins set at one edge are taken at the next, where the answer registers
  always @(posedge clk_sys_i) begin
    exp_p1 <= exp_bus;
  end

  // answers and state residency judged mid-cycle, where all is settled
  always @(negedge clk_sys_i) if (rst_n_i) begin
    chk_v("ok err", {6'h0, exp_p1}, {6'h0, cmd_ok_o, cmd_err_o});
    for (int b = 0; b < 4; b++)
      for (int k = 0; k < 8; k++)
        if (bank_st_o[b][k] === 1'b1) st_cnt[b][k]++;
    for (int k = 0; k < 4; k++)
      if (glob_st_o[k] === 1'b1) gl_cnt[k]++;
  end

  task automatic cmd(input sbl_cmd_t c, input logic [1:0] ba, input logic ap,
                     input logic [1:0] e);
    i_ctl.issue(c, ba, ap);
    exp_bus <= e;
  endtask : cmd

  task automatic nop(input int n);
    repeat (n) begin
      i_ctl.idle();
      exp_bus <= NO;
    end
  endtask : nop

  task automatic clr();
    foreach (st_cnt[b, k]) st_cnt[b][k] = 0;
    foreach (gl_cnt[k]) gl_cnt[k] = 0;
  endtask : clr

  // clock enable history and ready gate the check
  task automatic t_cke();
    // a level set right after a command is taken together with it
    cmd(CMD_NOP, 2'h0, 1'b0, NO);
    cmd(CMD_ACT, 2'h0, 1'b0, NO);
    cke_i <= 1'b0;
    cmd(CMD_ACT, 2'h0, 1'b0, NO);
    cke_i <= 1'b1;
    cmd(CMD_ACT, 2'h0, 1'b0, NO);
    ready_i <= 1'b0;
    cmd(CMD_ACT, 2'h0, 1'b0, OK);
    ready_i <= 1'b1;
    cmd(CMD_RD, 2'h2, 1'b0, ER);
    cmd(CMD_WR, 2'h3, 1'b1, ER);
    cmd(CMD_PRE, 2'h2, 1'b0, OK);
    cmd(CMD_PRE, 2'h0, 1'b0, OK);
    nop(5);
    @(negedge clk_sys_i);
    chk_v("all idle", 8'h1, {7'h0, all_idle_o});
  endtask : t_cke

  // one bank: activate window, burst cut, write after read
  task automatic t_same();
    clr();
    cmd(CMD_ACT, 2'h0, 1'b0, OK);
    nop(1);
    cmd(CMD_RD, 2'h0, 1'b0, ER);
    cmd(CMD_RD, 2'h0, 1'b0, OK);
    cmd(CMD_WR, 2'h0, 1'b0, ER);
    cmd(CMD_RD, 2'h0, 1'b0, OK);
    cmd(CMD_BST, 2'h2, 1'b0, OK);
    cmd(CMD_WR, 2'h0, 1'b0, OK);
    nop(6);
    cmd(CMD_PRE, 2'h0, 1'b0, OK);
    nop(1);
    cmd(CMD_ACT, 2'h0, 1'b0, ER);
    cmd(CMD_ACT, 2'h0, 1'b0, OK);
    nop(2);
    cmd(CMD_PRE, 2'h0, 1'b0, OK);
    nop(5);
    chk_n("acting cycles", 2 * RCD, st_cnt[0][1]);
    chk_n("precharge cycles", 2 * RP, st_cnt[0][7]);
    chk_n("read cycles", BUR + 1, st_cnt[0][3]);
  endtask : t_same

  // other banks run while one is busy, auto precharge split
  task automatic t_other();
    clr();
    cmd(CMD_ACT, 2'h1, 1'b0, OK);
    cmd(CMD_ACT, 2'h2, 1'b0, OK);
    nop(1);
    cmd(CMD_RD, 2'h1, 1'b1, OK);
    cmd(CMD_WR, 2'h2, 1'b1, OK);
    cmd(CMD_ACT, 2'h3, 1'b0, OK);
    cmd(CMD_RD, 2'h1, 1'b1, ER);
    nop(1);
    cmd(CMD_PRE, 2'h3, 1'b0, OK);
    nop(12);
    chk_n("read ap cycles", BUR, st_cnt[1][5]);
    chk_n("bank1 precharge", RP, st_cnt[1][7]);
    chk_n("write ap cycles", WAP, st_cnt[2][6]);
    chk_n("bank2 precharge", RP, st_cnt[2][7]);
    @(negedge clk_sys_i);
    chk_v("all idle", 8'h1, {7'h0, all_idle_o});
  endtask : t_other

  // device-wide windows: refresh, mode load, precharge all
  task automatic t_glob();
    clr();
    cmd(CMD_ACT, 2'h0, 1'b0, OK);
    nop(2);
    cmd(CMD_REF, 2'h0, 1'b0, ER);
    cmd(CMD_PRE, 2'h0, 1'b0, OK);
    nop(2);
    cmd(CMD_REF, 2'h0, 1'b0, OK);
    cmd(CMD_ACT, 2'h0, 1'b0, ER);
    nop(RFC - 2);
    cmd(CMD_LMR, 2'h0, 1'b0, OK);
    cmd(CMD_ACT, 2'h1, 1'b0, ER);
    cmd(CMD_ACT, 2'h1, 1'b0, OK);
    cmd(CMD_PREA, 2'h0, 1'b0, ER);
    nop(1);
    cmd(CMD_PREA, 2'h0, 1'b0, OK);
    cmd(CMD_ACT, 2'h0, 1'b0, ER);
    nop(1);
    cmd(CMD_ACT, 2'h0, 1'b0, OK);
    nop(2);
    cmd(CMD_PRE, 2'h0, 1'b0, OK);
    nop(5);
    chk_n("refresh cycles", RFC, gl_cnt[1]);
    chk_n("mode load cycles", MRD, gl_cnt[2]);
    chk_n("prea cycles", RP, gl_cnt[3]);
  endtask : t_glob

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // hang guard, far beyond the hundred-odd cycles of the run
  initial begin
    #5000;
    fail_count++;
    $display("unexpected watchdog: expected done seen running");
    test_done();
  end

  // main sequence
  initial begin
    rst_n_i = 1'b0;
    cke_i = 1'b1;
    ready_i = 1'b1;
    exp_bus = NO;
    fail_count = 0;
    n_tests = 0;
    clr();
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk_v("all idle", 8'h1, {7'h0, all_idle_o});
    chk_v("global", {4'h0, GL_RUN}, {4'h0, glob_st_o});
    for (int b = 0; b < 4; b++) chk_v("bank", BK_IDLE, bank_st_o[b]);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    nop(3);
    t_cke();
    t_same();
    t_other();
    t_glob();
    test_done();
  end
endmodule : test_sbl_bank_command_legality
